// ==== pmc_pkg.sv ====
// package for the misc pin and clock control register slice
package pmc_pkg;
	// ------------------------------------------------------------
	// register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_DRIVE_CTRL = 8'h80;
	localparam logic [7:0] ADDR_MISC_CTRL  = 8'h81;
	localparam logic [7:0] ADDR_DRIVE_STAT = 8'h82;
	localparam logic [7:0] RST_DRIVE_CTRL  = 8'h00;
	localparam logic [7:0] RST_MISC_CTRL   = 8'h00;
	localparam logic [7:0] RST_DRIVE_STAT  = 8'h08;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_DRV_CTRL   = 0;
	localparam int BIT_MAIN_RST   = 0;
	localparam int BIT_SOC_RST    = 1;
	localparam int BIT_LPM        = 2;
	localparam int BIT_CLKMON     = 3;
	localparam int BIT_REF_OUTPUT_PIN     = 4;
	localparam int BIT_EXT_SEL    = 5;
	localparam int BIT_SYNC_LO    = 6;
	localparam int BIT_FORCE_LOW  = 3;
	localparam int BIT_SPMI_LPM   = 4;

	// ------------------------------------------------------------
	// sync clock output timing, half periods in 100 MHz cycles
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int HALF_1P1       = CLK_MHZ * 10 / 22;
	localparam int HALF_2P2       = CLK_MHZ * 10 / 44;
	localparam int HALF_4P4       = CLK_MHZ * 10 / 88;
	// external clock is declared missing after this many cycles without an edge
	localparam int EXT_TIMEOUT    = 200;

	typedef enum logic [1:0] {
		SYNC_OFF,
		SYNC_1P1,
		SYNC_2P2,
		SYNC_4P4
	} pmc_sync_e;

	// register access request from host or sequencer
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} pmc_req_s;
endpackage

// ==== pmc_top.sv ====
// misc pin and clock control registers with pin drive and clock selection
`timescale 1ns/1ps
// Function
// - drive out pin follows the control bit unless force low is set, then it stays low.
// - sync clock select 00 off, 01 1.1 MHz, 10 2.2 MHz, 11 4.4 MHz.
// - with external select 0 the internal oscillator is always used.
// - with external select 1 a present external clock is used, else an interrupt is raised.
// - reference output enable routes the bandgap to the reference pin.
// - clock monitor enable switches clock monitoring on and off.
// - low power mode stops thermal cycling, crc checking, watchdog polling and monitoring.
// - the power sequencer is expected to set low power mode entering deep sleep.
// - soc reset control bit sets the soc reset output level.
// - main reset control bit sets the main reset output level.
// - force low is writable only by the sequencer and blocks host setting the drive bit.
// - the status register reports the live levels of the three pins.
module pmc_top
(
	input  wire logic            i_clk,
	input  wire logic            i_reset,
	input  wire pmc_pkg::pmc_req_s i_host_req,
	input  wire logic            i_host_valid,
	input  wire pmc_pkg::pmc_req_s i_seq_req,
	input  wire logic            i_seq_valid,
	input  wire logic            i_drive_out_level,
	input  wire logic            i_main_reset_level,
	input  wire logic            i_soc_reset_level,
	input  wire logic            i_ext_clk,
	output logic [7:0]           o_rdata,
	output logic                 o_rvalid,
	output logic                 o_drive_out_pin,
	output logic                 o_main_reset_out,
	output logic                 o_soc_reset_out,
	output logic                 o_ref_output_pin,
	output logic                 o_sync_clk_out_pin,
	output logic                 o_use_ext_clk,
	output logic                 o_ext_clk_irq,
	output logic                 o_clock_monitor_on,
	output logic                 o_thermal_cycling_on,
	output logic                 o_crc_check_on,
	output logic                 o_wd_poll_on
);
	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [7:0] drv_ctrl_q;
	logic [7:0] misc_q;
	logic [7:0] stat_q;
	logic [7:0] live_q;
	logic       host_wr;
	logic       seq_wr;

	assign host_wr = i_host_valid && i_host_req.wr;
	assign seq_wr  = i_seq_valid && i_seq_req.wr;

	// sequencer wins when both write the same register in one cycle
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			drv_ctrl_q <= pmc_pkg::RST_DRIVE_CTRL;
		else if (seq_wr && i_seq_req.addr == pmc_pkg::ADDR_DRIVE_CTRL)
			drv_ctrl_q <= i_seq_req.data;
		else if (host_wr && i_host_req.addr == pmc_pkg::ADDR_DRIVE_CTRL)
		begin
			drv_ctrl_q[7:1] <= i_host_req.data[7:1];
			// host cannot raise the bit while force low holds, so it stays cleared
			drv_ctrl_q[0] <= i_host_req.data[pmc_pkg::BIT_DRV_CTRL]
				&& !stat_q[pmc_pkg::BIT_FORCE_LOW];
		end
		else if (stat_q[pmc_pkg::BIT_FORCE_LOW])
			drv_ctrl_q[0] <= 1'b0; // forced low clears the control bit
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			misc_q <= pmc_pkg::RST_MISC_CTRL;
		else if (seq_wr && i_seq_req.addr == pmc_pkg::ADDR_MISC_CTRL)
			misc_q <= i_seq_req.data; // sequencer may set low power mode
		else if (host_wr && i_host_req.addr == pmc_pkg::ADDR_MISC_CTRL)
			misc_q <= i_host_req.data;
	end

	// status writable bits belong to the sequencer only
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			stat_q <= pmc_pkg::RST_DRIVE_STAT;
		else if (seq_wr && i_seq_req.addr == pmc_pkg::ADDR_DRIVE_STAT)
			stat_q <= {i_seq_req.data[7:3], 3'b000};
	end

	// live pin levels, sampled once to keep reads clean
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			live_q <= 8'h00;
		else
			live_q <= {5'b0_0000, i_soc_reset_level, i_main_reset_level, i_drive_out_level};
	end

	// ------------------------------------------------------------
	// read port, host reads take priority of the single data output
	// ------------------------------------------------------------
	function automatic logic [7:0] read_reg(input logic [7:0] addr);
		case (addr)
			pmc_pkg::ADDR_DRIVE_CTRL: read_reg = drv_ctrl_q;
			pmc_pkg::ADDR_MISC_CTRL:  read_reg = misc_q;
			pmc_pkg::ADDR_DRIVE_STAT: read_reg = {stat_q[7:3], live_q[2:0]};
			default:                  read_reg = 8'h00;
		endcase
	endfunction

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_rdata  <= 8'h00;
			o_rvalid <= 1'b0;
		end
		else if (i_host_valid && !i_host_req.wr)
		begin
			o_rdata  <= read_reg(i_host_req.addr);
			o_rvalid <= 1'b1;
		end
		else if (i_seq_valid && !i_seq_req.wr)
		begin
			o_rdata  <= read_reg(i_seq_req.addr);
			o_rvalid <= 1'b1;
		end
		else
			o_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_drive_out_pin  <= 1'b0;
			o_main_reset_out <= 1'b0;
			o_soc_reset_out  <= 1'b0;
			o_ref_output_pin <= 1'b0;
		end
		else
		begin
			o_drive_out_pin  <= drv_ctrl_q[0] && !stat_q[pmc_pkg::BIT_FORCE_LOW];
			o_main_reset_out <= misc_q[pmc_pkg::BIT_MAIN_RST];
			o_soc_reset_out  <= misc_q[pmc_pkg::BIT_SOC_RST];
			o_ref_output_pin <= misc_q[pmc_pkg::BIT_REF_OUTPUT_PIN];
		end
	end

	// low power mode gates background activities
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_clock_monitor_on   <= 1'b0;
			o_thermal_cycling_on <= 1'b0;
			o_crc_check_on       <= 1'b0;
			o_wd_poll_on         <= 1'b0;
		end
		else
		begin
			o_clock_monitor_on   <= misc_q[pmc_pkg::BIT_CLKMON] && !misc_q[pmc_pkg::BIT_LPM];
			o_thermal_cycling_on <= !misc_q[pmc_pkg::BIT_LPM];
			o_crc_check_on       <= !misc_q[pmc_pkg::BIT_LPM];
			o_wd_poll_on         <= !misc_q[pmc_pkg::BIT_LPM] && !stat_q[pmc_pkg::BIT_SPMI_LPM];
		end
	end

	// ------------------------------------------------------------
	// sync clock output divider
	// ------------------------------------------------------------
	logic [5:0] sync_cnt_q;
	logic [5:0] sync_half;
	pmc_pkg::pmc_sync_e sync_sel;

	assign sync_sel = pmc_pkg::pmc_sync_e'(misc_q[pmc_pkg::BIT_SYNC_LO +: 2]);

	// integer halves give approximate rates; 100 MHz does not divide evenly
	always_comb
	begin
		case (sync_sel)
			pmc_pkg::SYNC_1P1: sync_half = 6'(pmc_pkg::HALF_1P1);
			pmc_pkg::SYNC_2P2: sync_half = 6'(pmc_pkg::HALF_2P2);
			pmc_pkg::SYNC_4P4: sync_half = 6'(pmc_pkg::HALF_4P4);
			default:           sync_half = 6'h00;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset || sync_sel == pmc_pkg::SYNC_OFF)
		begin
			sync_cnt_q         <= 6'h00;
			o_sync_clk_out_pin <= 1'b0;
		end
		else if (sync_cnt_q >= sync_half - 6'h01)
		begin
			sync_cnt_q         <= 6'h00;
			o_sync_clk_out_pin <= !o_sync_clk_out_pin;
		end
		else
			sync_cnt_q <= sync_cnt_q + 6'h01;
	end

	// ------------------------------------------------------------
	// external clock detect and selection
	// ------------------------------------------------------------
	logic [7:0] ext_idle_q;
	logic       ext_prev_q;
	logic       ext_ok;

	assign ext_ok = ext_idle_q < 8'(pmc_pkg::EXT_TIMEOUT);

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ext_prev_q <= 1'b0;
			ext_idle_q <= 8'(pmc_pkg::EXT_TIMEOUT);
		end
		else
		begin
			ext_prev_q <= i_ext_clk;
			if (i_ext_clk != ext_prev_q)
				ext_idle_q <= 8'h00;
			else if (ext_ok)
				ext_idle_q <= ext_idle_q + 8'h01;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_use_ext_clk <= 1'b0;
			o_ext_clk_irq <= 1'b0;
		end
		else
		begin
			o_use_ext_clk <= misc_q[pmc_pkg::BIT_EXT_SEL] && ext_ok;
			o_ext_clk_irq <= misc_q[pmc_pkg::BIT_EXT_SEL] && !ext_ok;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	force_low_pin_a: assert property (@(posedge i_clk) disable iff (i_reset)
		$past(stat_q[pmc_pkg::BIT_FORCE_LOW]) |-> !o_drive_out_pin)
		else $error("drive pin high under force low");
	drive_follow_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!$past(stat_q[pmc_pkg::BIT_FORCE_LOW]) |-> o_drive_out_pin == $past(drv_ctrl_q[0]))
		else $error("drive pin not following control");
	host_blocked_a: assert property (@(posedge i_clk) disable iff (i_reset)
		stat_q[pmc_pkg::BIT_FORCE_LOW] && !seq_wr |=> !drv_ctrl_q[0])
		else $error("host raised drive bit under force low");
	int_clock_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!misc_q[pmc_pkg::BIT_EXT_SEL] |=> !o_use_ext_clk && !o_ext_clk_irq)
		else $error("external clock used while internal forced");
	lpm_monitor_a: assert property (@(posedge i_clk) disable iff (i_reset)
		misc_q[pmc_pkg::BIT_LPM] |=> !o_clock_monitor_on && !o_crc_check_on)
		else $error("monitoring active in low power mode");
	reset_pins_a: assert property (@(posedge i_clk) disable iff (i_reset)
		##1 o_soc_reset_out == $past(misc_q[1]) && o_main_reset_out == $past(misc_q[0]))
		else $error("reset outputs do not follow control");
	sync_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
		sync_sel == pmc_pkg::SYNC_OFF |=> !o_sync_clk_out_pin)
		else $error("sync clock runs while off");
	// eleven edges at 4.4 MHz hold exactly one toggle, the half period being eleven cycles
	sync_toggle_a: assert property (@(posedge i_clk) disable iff (i_reset)
		(sync_sel == pmc_pkg::SYNC_4P4) [*8] ##1 (sync_sel == pmc_pkg::SYNC_4P4) [*3]
		|=> o_sync_clk_out_pin != $past(o_sync_clk_out_pin, 11))
		else $error("sync clock stalls");
	ext_irq_a: assert property (@(posedge i_clk) disable iff (i_reset)
		misc_q[pmc_pkg::BIT_EXT_SEL] && !ext_ok |=> o_ext_clk_irq)
		else $error("missing external clock not flagged");
	ref_out_a: assert property (@(posedge i_clk) disable iff (i_reset)
		##1 o_ref_output_pin == $past(misc_q[pmc_pkg::BIT_REF_OUTPUT_PIN]))
		else $error("reference output wrong");
endmodule

// ==== pmc_host_model.sv ====
// request driver standing in for the host or the power sequencer
`timescale 1ns/1ps
module pmc_host_model
(
	input  wire logic         i_clk,
	output pmc_pkg::pmc_req_s o_req,
	output logic              o_valid
);
	// idle with no request pending at time zero
	initial
	begin
		o_req   = '0;
		o_valid = 1'b0;
	end

	// one-cycle request, fields held up to the taking edge
	task automatic send(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge i_clk);
		o_req   <= '{wr: wr, addr: addr, data: data};
		o_valid <= 1'b1;
		@(posedge i_clk);
		o_valid <= 1'b0;
		// released fields show the inverse so stale values cannot pass
		o_req   <= '{wr: ~wr, addr: ~addr, data: ~data};
	endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the misc pin and clock control slice
`timescale 1ns/1ps
module tb;
	logic              i_clk = 0, i_reset = 1, i_ext_clk = 0, ext_run = 0;
	logic              i_drive_out_level = 0, i_main_reset_level = 0, i_soc_reset_level = 0;
	logic [1:0]        ext_div = 0;
	pmc_pkg::pmc_req_s i_host_req, i_seq_req;
	logic              i_host_valid, i_seq_valid, o_rvalid, o_drive_out_pin, o_main_reset_out;
	logic              o_soc_reset_out, o_ref_output_pin, o_sync_clk_out_pin, o_use_ext_clk;
	logic              o_ext_clk_irq, o_clock_monitor_on, o_thermal_cycling_on, o_crc_check_on;
	logic              o_wd_poll_on;
	logic [7:0]        o_rdata;
	int                fail_count = 0, n_compared = 0;

	pmc_top u_pmc_top (.i_clk, .i_reset, .i_host_req, .i_host_valid, .i_seq_req, .i_seq_valid,
		.i_drive_out_level, .i_main_reset_level, .i_soc_reset_level, .i_ext_clk, .o_rdata,
		.o_rvalid, .o_drive_out_pin, .o_main_reset_out, .o_soc_reset_out, .o_ref_output_pin,
		.o_sync_clk_out_pin, .o_use_ext_clk, .o_ext_clk_irq, .o_clock_monitor_on,
		.o_thermal_cycling_on, .o_crc_check_on, .o_wd_poll_on);
	pmc_host_model u_pmc_host_model (.i_clk, .o_req(i_host_req), .o_valid(i_host_valid));
	pmc_host_model u_pmc_host_model_seq (.i_clk, .o_req(i_seq_req), .o_valid(i_seq_valid));

	// 100 MHz clock
	always #5 i_clk = ~i_clk;

	// external sync clock, stands still while not running
	always @(posedge i_clk)
	begin
		if (ext_run)
		begin
			ext_div <= ext_div + 2'd1;
			if (ext_div == 2'd3)
				i_ext_clk <= ~i_ext_clk;
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// write, then let register and pins settle
	task automatic wr(input logic seq, input logic [7:0] a, input logic [7:0] d);
		if (seq)
			u_pmc_host_model_seq.send(1'b1, a, d);
		else
			u_pmc_host_model.send(1'b1, a, d);
		repeat (3) @(posedge i_clk);
		#1;
	endtask

	// read with a bounded wait on the answer pulse
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
		u_pmc_host_model.send(1'b0, a, 8'h00);
		#1;
		for (int k = 0; k < 4 && o_rvalid !== 1'b1; k++)
		begin
			@(posedge i_clk);
			#1;
		end
		chk({7'd0, o_rvalid}, 8'h01, "rvalid");
		chk(o_rdata, exp, what);
	endtask

	function automatic logic [7:0] pins();
		return {o_wd_poll_on, o_crc_check_on, o_thermal_cycling_on, o_clock_monitor_on,
			o_ref_output_pin, o_soc_reset_out, o_main_reset_out, o_drive_out_pin};
	endfunction

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk(pins(), 8'hE0, "pins after reset");
		rdc(pmc_pkg::ADDR_DRIVE_CTRL, pmc_pkg::RST_DRIVE_CTRL, "drive ctrl reset");
		rdc(pmc_pkg::ADDR_MISC_CTRL, pmc_pkg::RST_MISC_CTRL, "misc reset");
		rdc(pmc_pkg::ADDR_DRIVE_STAT, pmc_pkg::RST_DRIVE_STAT, "stat reset");
		rdc(8'h90, 8'h00, "unmapped read");
		$display("test reset done");
	endtask

	task automatic t_force_low();
		wr(0, 8'h80, 8'h01);
		chk({7'd0, o_drive_out_pin}, 8'h00, "drive blocked");
		rdc(8'h80, 8'h00, "drive bit refused");
		wr(0, 8'h82, 8'h00);
		rdc(8'h82, 8'h08, "host stat write");
		wr(0, 8'h80, 8'hFE);
		rdc(8'h80, 8'hFE, "reserved store");
		wr(1, 8'h82, 8'h00);
		wr(0, 8'h80, 8'h01);
		chk({7'd0, o_drive_out_pin}, 8'h01, "drive high");
		wr(0, 8'h80, 8'hFF);
		chk({7'd0, o_drive_out_pin}, 8'h01, "reserved no effect");
		rdc(8'h80, 8'hFF, "reserved readback");
		wr(1, 8'h82, 8'h08);
		chk({7'd0, o_drive_out_pin}, 8'h00, "forced low");
		$display("test force low done");
	endtask

	task automatic t_misc();
		logic [7:0] dat [5] = '{8'h03, 8'h10, 8'h08, 8'h0C, 8'h04};
		logic [7:0] exp [5] = '{8'hE6, 8'hE8, 8'hF0, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++)
		begin
			wr(0, 8'h81, dat[i]);
			chk(pins(), exp[i], "misc pins");
			rdc(8'h81, dat[i], "misc readback");
		end
		@(posedge i_clk);
		{i_soc_reset_level, i_main_reset_level, i_drive_out_level} <= 3'b101;
		rdc(8'h82, 8'h0D, "live levels");
		// sequencer-only low power bit of the status register stops polling
		wr(0, 8'h81, 8'h00);
		wr(1, 8'h82, 8'h18);
		chk(pins(), 8'h60, "status low power stops polling");
		rdc(8'h82, 8'h1D, "status low power readback");
		wr(1, 8'h82, 8'h08);
		$display("test misc done");
	endtask

	task automatic t_sync();
		int half [4] = '{0, pmc_pkg::HALF_1P1, pmc_pkg::HALF_2P2, pmc_pkg::HALF_4P4};
		int n, e;
		logic prev;
		for (int s = 0; s < 4; s++)
		begin
			wr(0, 8'h81, {s[1:0], 6'd0});
			n = 0;
			prev = o_sync_clk_out_pin;
			repeat (2000)
			begin
				@(posedge i_clk);
				#1;
				if (o_sync_clk_out_pin !== prev)
					n++;
				prev = o_sync_clk_out_pin;
			end
			e = (s == 0) ? 0 : 2000 / half[s];
			chk({7'd0, n >= e - 2 && n <= e + 2}, 8'h01, "sync toggles");
		end
		$display("test sync done");
	endtask

	task automatic t_ext();
		ext_run <= 1'b1;
		wr(0, 8'h81, 8'h00);
		repeat (50) @(posedge i_clk);
		#1;
		chk({6'd0, o_use_ext_clk, o_ext_clk_irq}, 8'h00, "internal forced");
		wr(0, 8'h81, 8'h20);
		repeat (50) @(posedge i_clk);
		#1;
		chk({6'd0, o_use_ext_clk, o_ext_clk_irq}, 8'h02, "ext used");
		ext_run <= 1'b0;
		repeat (pmc_pkg::EXT_TIMEOUT + 20) @(posedge i_clk);
		#1;
		chk({6'd0, o_use_ext_clk, o_ext_clk_irq}, 8'h01, "ext missing");
		$display("test ext done");
	endtask

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// main sequence after three reset cycles
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		t_reset();
		t_force_low();
		t_misc();
		t_sync();
		t_ext();
		final_report();
	end

	// watchdog, about twice the expected run
	initial
	begin
		#200us;
		fail_count++;
		final_report();
	end
endmodule
